// ===== bus_mem_ctrl.sv
/*
 * Memory controller for a single-master processor bus: decodes each
 * transfer, drives burst SRAM, flash and I/O strobes, and ends every
 * transfer with data/address acknowledges or an error acknowledge.
 * Assumes the bus master is clocked by clk and is permanently parked.
 */
// Overview of operation
// - flash only single beats, never bursts
// - shared flash output enable on flash reads
// - flash writes qualified by byte strobes
// - byte strobes active low, none means read
// - flash chip select on every flash access
// - flash acknowledge held off fixed clocks
// - I/O accepts any write size
// - I/O writes reuse memory byte strobes
// - I/O delay chosen per address range
// - transfer start sampled on bus clock
// - type, size, burst classify the transfer
// - top two address bits select region
// - low address bits and size give lanes
// - address acknowledge on final beat
// - one data acknowledge per beat
// - unsupported transfers end with error acknowledge
// - SRAM chip select on every RAM access
// - SRAM output enable on RAM reads only
// - SRAM address strobe before first beat
// - burst advance during beats two to four
// - I/O selects on access, enable on reads
// - bus grant and busy not monitored
// - SRAM select and address strobe together
// - burst advance three clocks, high otherwise
// - deselect cycle after each SRAM access
`timescale 1ns/1ps
module bus_mem_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] address,
    input wire logic transfer_start_n,
    input wire logic [4:0] transfer_type,
    input wire logic [2:0] transfer_size,
    input wire logic burst_indicator_n,
    output logic address_ack_n,
    output logic data_transfer_ack_n,
    output logic transfer_error_ack_n,
    output logic [7:0] byte_write_strobe_n,
    output logic flash_chip_select_n,
    output logic flash_output_enable_n,
    output logic sram_chip_select_n,
    output logic sram_output_enable_n,
    output logic sram_address_strobe_n,
    output logic sram_burst_advance_n,
    output logic [1:0] io_chip_select_n,
    output logic io_output_enable_n
);

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        mbc_pkg::state_t st;
        logic [1:0] beat;
        logic [3:0] cnt;
        logic burst;
        logic pend_v;
        logic [mbc_pkg::REQ_W-1:0] pend;
        logic address_ack_n_n;
        logic ta_n;
        logic tea_n;
        logic [7:0] bws_n;
        logic fcs_n;
        logic foe_n;
        logic scs_n;
        logic soe_n;
        logic sram_address_strobe_n_n;
        logic adv_n;
        logic [1:0] xcs_n;
        logic xoe_n;
    } ctl_t;

    ctl_t r;
    ctl_t nxt;

    logic [mbc_pkg::REQ_W-1:0] cur_req;
    logic in_valid;
    logic in_ready;
    logic [mbc_pkg::REQ_W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [mbc_pkg::REQ_W-1:0] head;

    logic [31:0] h_addr;
    logic [4:0] h_tt;
    logic [2:0] h_size;
    logic h_burst;
    mbc_pkg::region_t h_rgn;
    logic h_write;
    logic h_type_ok;
    logic h_ok;
    logic [7:0] h_lanes;
    logic [3:0] h_wait;

    // ********************************************************************
    // helpers
    // ********************************************************************
    function automatic logic [3:0] byte_count(input logic [2:0] sz);
        return (sz == 3'h0) ? mbc_pkg::BUS_BYTES : {1'b0, sz};
    endfunction : byte_count

    // lane 0 is the lowest byte address of the doubleword
    function automatic logic [7:0] lane_mask(input logic [2:0] off, input logic [2:0] sz);
        logic [7:0] m;
        logic [3:0] lo;
        logic [3:0] hi;
        m = 8'h00;
        lo = {1'b0, off};
        hi = lo + byte_count(sz);
        for (int i = 0; i < 8; i++) begin
            if (4'(i) >= lo && 4'(i) < hi) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : lane_mask

    // ********************************************************************
    // start detection into the request fifo
    // ********************************************************************
    // bus grant/busy are never examined: the master is always parked
    assign cur_req = {~burst_indicator_n, transfer_size, transfer_type, address};
    assign in_valid = r.pend_v || !transfer_start_n;
    assign in_data = r.pend_v ? r.pend : cur_req;

    req_fifo #(
        .WIDTH(mbc_pkg::REQ_W),
        .DEPTH(mbc_pkg::REQ_DEPTH)
    ) u_req_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(head)
    );

    // ********************************************************************
    // classification of the head request
    // ********************************************************************
    assign h_addr = head[31:0];
    assign h_tt = head[mbc_pkg::REQ_TT_LSB +: 5];
    assign h_size = head[mbc_pkg::REQ_SIZE_LSB +: 3];
    assign h_burst = head[mbc_pkg::REQ_BURST_BIT];
    assign h_rgn = mbc_pkg::region_t'(h_addr[31:30]);
    assign h_write = (h_tt == mbc_pkg::TT_WRITE_FLUSH) || (h_tt == mbc_pkg::TT_WRITE_KILL);
    assign h_type_ok = h_write || (h_tt == mbc_pkg::TT_READ) || (h_tt == mbc_pkg::TT_READ_MODIFY);

    // bursts only to RAM; single beats must not cross the doubleword
    always_comb begin
        h_ok = h_type_ok;
        if (h_burst && h_rgn != mbc_pkg::REG_RAM) begin
            h_ok = 1'b0;
        end
        if (!h_burst && ({1'b0, h_addr[2:0]} + byte_count(h_size)) > mbc_pkg::BUS_BYTES) begin
            h_ok = 1'b0;
        end
    end

    // a burst moves whole doublewords on every lane
    assign h_lanes = h_burst ? 8'hFF : lane_mask(h_addr[2:0], h_size);

    always_comb begin
        unique case (h_rgn)
            mbc_pkg::REG_FAST_IO: h_wait = mbc_pkg::FAST_IO_CYCLES;
            mbc_pkg::REG_SLOW_IO: h_wait = mbc_pkg::SLOW_IO_CYCLES;
            mbc_pkg::REG_FLASH: h_wait = mbc_pkg::FLASH_CYCLES;
            mbc_pkg::REG_RAM: h_wait = 4'h0;
        endcase
    end

    assign out_ready = (r.st == mbc_pkg::ST_IDLE);

    // ********************************************************************
    // cycle engine
    // ********************************************************************
    always_comb begin
        nxt = r;
        nxt.address_ack_n_n = 1'b1;
        nxt.ta_n = 1'b1;
        nxt.tea_n = 1'b1;
        nxt.sram_address_strobe_n_n = 1'b1;
        nxt.adv_n = 1'b1;

        // a start that meets a full fifo waits here instead of being lost
        if (r.pend_v) begin
            if (in_ready) begin
                nxt.pend_v = !transfer_start_n;
                nxt.pend = cur_req;
            end
        end else if (!transfer_start_n && !in_ready) begin
            nxt.pend_v = 1'b1;
            nxt.pend = cur_req;
        end

        unique case (r.st)
            mbc_pkg::ST_IDLE: begin
                if (out_valid) begin
                    nxt.burst = h_burst;
                    if (!h_ok) begin
                        nxt.st = mbc_pkg::ST_ERR;
                        nxt.tea_n = 1'b0;
                        nxt.address_ack_n_n = 1'b0;
                    end else if (h_rgn == mbc_pkg::REG_RAM) begin
                        nxt.st = mbc_pkg::ST_ADDR;
                        nxt.scs_n = 1'b0;
                        nxt.sram_address_strobe_n_n = 1'b0;
                        nxt.soe_n = h_write;
                        nxt.bws_n = h_write ? ~h_lanes : mbc_pkg::LANES_NEGATED;
                    end else begin
                        nxt.st = mbc_pkg::ST_WAIT;
                        nxt.cnt = h_wait - 4'h1;
                        nxt.bws_n = h_write ? ~h_lanes : mbc_pkg::LANES_NEGATED;
                        if (h_rgn == mbc_pkg::REG_FLASH) begin
                            nxt.fcs_n = 1'b0;
                            nxt.foe_n = h_write;
                        end else begin
                            nxt.xcs_n[0] = (h_rgn != mbc_pkg::REG_FAST_IO);
                            nxt.xcs_n[1] = (h_rgn != mbc_pkg::REG_SLOW_IO);
                            nxt.xoe_n = h_write;
                        end
                    end
                end
            end
            // pipelined sram: data lags the latched address by one clock, so wait one
            mbc_pkg::ST_ADDR: begin
                if (!r.sram_address_strobe_n_n) begin
                    nxt.st = mbc_pkg::ST_ADDR;
                end else begin
                    nxt.st = mbc_pkg::ST_BEAT;
                    nxt.beat = 2'h0;
                    nxt.ta_n = 1'b0;
                    nxt.address_ack_n_n = r.burst;
                end
            end
            mbc_pkg::ST_BEAT: begin
                if (!r.burst || r.beat == mbc_pkg::BURST_LAST_BEAT) begin
                    nxt.st = mbc_pkg::ST_DESEL;
                    nxt.scs_n = 1'b1;
                    nxt.sram_address_strobe_n_n = 1'b0;
                    nxt.soe_n = 1'b1;
                    nxt.bws_n = mbc_pkg::LANES_NEGATED;
                end else begin
                    nxt.beat = r.beat + 2'h1;
                    nxt.ta_n = 1'b0;
                    nxt.adv_n = 1'b0;
                    nxt.address_ack_n_n = (r.beat + 2'h1 != mbc_pkg::BURST_LAST_BEAT);
                end
            end
            mbc_pkg::ST_DESEL: begin
                nxt.st = mbc_pkg::ST_IDLE;
            end
            mbc_pkg::ST_WAIT: begin
                if (r.cnt == 4'h1) begin
                    nxt.cnt = 4'h0;
                    nxt.ta_n = 1'b0;
                    nxt.address_ack_n_n = 1'b0;
                end else if (r.cnt == 4'h0) begin
                    nxt.st = mbc_pkg::ST_IDLE;
                    nxt.fcs_n = 1'b1;
                    nxt.foe_n = 1'b1;
                    nxt.xcs_n = mbc_pkg::IO_CS_NEGATED;
                    nxt.xoe_n = 1'b1;
                    nxt.bws_n = mbc_pkg::LANES_NEGATED;
                end else begin
                    nxt.cnt = r.cnt - 4'h1;
                end
            end
            mbc_pkg::ST_ERR: begin
                nxt.st = mbc_pkg::ST_IDLE;
            end
            default: begin
                nxt.st = mbc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{st: mbc_pkg::ST_IDLE, beat: 2'h0, cnt: 4'h0, burst: 1'b0,
                   pend_v: 1'b0, pend: '0, address_ack_n_n: 1'b1, ta_n: 1'b1, tea_n: 1'b1,
                   bws_n: mbc_pkg::LANES_NEGATED, fcs_n: 1'b1, foe_n: 1'b1,
                   scs_n: 1'b1, soe_n: 1'b1, sram_address_strobe_n_n: 1'b1, adv_n: 1'b1,
                   xcs_n: mbc_pkg::IO_CS_NEGATED, xoe_n: 1'b1};
        end else begin
            r <= nxt;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    assign address_ack_n = r.address_ack_n_n;
    assign data_transfer_ack_n = r.ta_n;
    assign transfer_error_ack_n = r.tea_n;
    assign byte_write_strobe_n = r.bws_n;
    assign flash_chip_select_n = r.fcs_n;
    assign flash_output_enable_n = r.foe_n;
    assign sram_chip_select_n = r.scs_n;
    assign sram_output_enable_n = r.soe_n;
    assign sram_address_strobe_n = r.sram_address_strobe_n_n;
    assign sram_burst_advance_n = r.adv_n;
    assign io_chip_select_n = r.xcs_n;
    assign io_output_enable_n = r.xoe_n;

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_FLASH_NO_BURST: assert property (
        (r.st == mbc_pkg::ST_IDLE && out_valid && h_burst && h_rgn == mbc_pkg::REG_FLASH)
        |=> !transfer_error_ack_n && flash_chip_select_n)
        else $error("burst to flash was not refused");
    AST_FLASH_READ_OE: assert property (
        !flash_output_enable_n |-> !flash_chip_select_n && byte_write_strobe_n == 8'hFF)
        else $error("flash output enable outside a flash read");
    AST_FLASH_WRITE: assert property (
        !flash_chip_select_n && byte_write_strobe_n != 8'hFF |-> flash_output_enable_n)
        else $error("flash write with output enable low");
    AST_FLASH_DELAY: assert property (
        $fell(flash_chip_select_n) |-> data_transfer_ack_n [*5] ##1 !data_transfer_ack_n)
        else $error("flash acknowledge not after six clocks");
    AST_ADDRESS_ACK_N_FINAL: assert property (
        !address_ack_n |-> !data_transfer_ack_n || !transfer_error_ack_n)
        else $error("address acknowledge without final beat");
    AST_TEA_ALONE: assert property (
        !transfer_error_ack_n |-> data_transfer_ack_n && !address_ack_n)
        else $error("error acknowledge mixed with data acknowledge");
    AST_SRAM_START: assert property (
        $fell(sram_chip_select_n) |-> !sram_address_strobe_n ##1 sram_address_strobe_n ##1 !data_transfer_ack_n)
        else $error("sram select and address strobe out of step");
    AST_BURST_ADV: assert property (
        $fell(sram_burst_advance_n) |-> !sram_burst_advance_n [*3] ##1 sram_burst_advance_n)
        else $error("burst advance not three clocks");
    AST_DESELECT: assert property (
        $rose(sram_chip_select_n) |-> !sram_address_strobe_n)
        else $error("no deselect cycle after sram access");
    AST_IO_OE: assert property (
        !io_output_enable_n |-> io_chip_select_n != 2'h3)
        else $error("io output enable without chip select");

    COV_SRAM_BURST: cover property (!sram_burst_advance_n ##1 !sram_burst_advance_n ##1 !address_ack_n);
    COV_FLASH_WRITE: cover property (!flash_chip_select_n && byte_write_strobe_n != 8'hFF);
    COV_SLOW_IO: cover property (!io_chip_select_n[1] && !data_transfer_ack_n);
    COV_ERROR: cover property (!transfer_error_ack_n);

endmodule : bus_mem_ctrl

// ===== mbc_pkg.sv
/*
 * Shared constants for the minimal bus memory controller: transfer type
 * codes, region decode, wait counts, request word layout and states.
 * Assumes a single bus master running on the same clock as the controller.
 */
package mbc_pkg;

    // ********************************************************************
    // transfer types accepted (transfer_type[4] is the first bit)
    // ********************************************************************
    localparam logic [4:0] TT_WRITE_FLUSH = 5'h02;
    localparam logic [4:0] TT_WRITE_KILL = 5'h06;
    localparam logic [4:0] TT_READ = 5'h0A;
    localparam logic [4:0] TT_READ_MODIFY = 5'h0E;

    // ********************************************************************
    // regions selected by the two top address bits
    // ********************************************************************
    typedef enum logic [1:0] {
        REG_RAM = 2'b00,
        REG_FAST_IO = 2'b01,
        REG_SLOW_IO = 2'b10,
        REG_FLASH = 2'b11
    } region_t;

    // ********************************************************************
    // access times in bus clocks, transfer start edge to data acknowledge; last burst beat index and bus width in bytes
    // ********************************************************************
    localparam logic [3:0] FAST_IO_CYCLES = 4'h4;
    localparam logic [3:0] SLOW_IO_CYCLES = 4'hC;
    localparam logic [3:0] FLASH_CYCLES = 4'h6;
    localparam logic [1:0] BURST_LAST_BEAT = 2'h3;
    localparam logic [3:0] BUS_BYTES = 4'h8;

    // ********************************************************************
    // request word carried through the fifo
    // ********************************************************************
    localparam int REQ_W = 41;
    localparam int REQ_DEPTH = 16;
    localparam int REQ_TT_LSB = 32;
    localparam int REQ_SIZE_LSB = 37;
    localparam int REQ_BURST_BIT = 40;

    // ********************************************************************
    // strobe reset values and cycle states
    // ********************************************************************
    localparam logic [7:0] LANES_NEGATED = 8'hFF;
    localparam logic [1:0] IO_CS_NEGATED = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_BEAT = 3'b010,
        ST_DESEL = 3'b011,
        ST_WAIT = 3'b100,
        ST_ERR = 3'b101
    } state_t;

endpackage : mbc_pkg

// ===== req_fifo.sv
/*
 * Synchronous valid/ready fifo with parameterised width and depth.
 * Assumes one clock; the head word is shown while out_valid is high.
 */
`timescale 1ns/1ps
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ptr_t;

    ptr_t r;
    ptr_t nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    // ********************************************************************
    // pointers carry one wrap bit so full and empty differ
    // ********************************************************************
    assign empty = (r.wp == r.rp);
    assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[r.rp[AW-1:0]];

    always_comb begin
        nxt = r;
        if (in_valid && !full) begin
            nxt.wp = r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            nxt.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // storage needs no reset; only words behind the pointers are read
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[r.wp[AW-1:0]] <= in_data;
        end
    end

endmodule : req_fifo

// ===== bus_master_model.sv
/*
 * Behavioural model of the sole bus master: issues one transfer at a time
 * and times the acknowledges that come back, in cycles after the start edge.
 * Assumes callers enter issue() just after a rising clock edge.
 */
`timescale 1ns/1ps
module bus_master_model (
    input wire logic clk,
    output logic [31:0] address,
    output logic transfer_start_n,
    output logic [4:0] transfer_type,
    output logic [2:0] transfer_size,
    output logic burst_indicator_n,
    input wire logic address_ack_n,
    input wire logic data_transfer_ack_n,
    input wire logic transfer_error_ack_n
);
    int ta_count;
    int first_ta;
    int address_ack_n_cyc;
    int tea_cyc;

    initial begin
        address = 32'h0;
        transfer_start_n = 1'b1;
        transfer_type = 5'h00;
        transfer_size = 3'h0;
        burst_indicator_n = 1'b1;
    end

    // ********************************************************************
    // one transfer; request held until the edge after the address ack
    // ********************************************************************
    task automatic issue(input logic [31:0] a, input logic [4:0] tt, input logic [2:0] sz, input logic bn);
        ta_count = 0;
        first_ta = 0;
        address_ack_n_cyc = 0;
        tea_cyc = 0;
        address = a;
        transfer_type = tt;
        transfer_size = sz;
        burst_indicator_n = bn;
        transfer_start_n = 1'b0;
        @(posedge clk);
        #1;
        transfer_start_n = 1'b1;
        for (int k = 1; k <= 20 && address_ack_n_cyc == 0; k++) begin
            @(posedge clk);
            #1;
            if (data_transfer_ack_n === 1'b0) begin
                ta_count++;
                if (first_ta == 0) begin
                    first_ta = k;
                end
            end
            if (transfer_error_ack_n === 1'b0) begin
                tea_cyc = k;
            end
            if (address_ack_n === 1'b0) begin
                address_ack_n_cyc = k;
            end
        end
        @(posedge clk);
        #1;
        // released bus must not keep showing the old address
        address = ~a;
        transfer_type = ~tt;
    endtask : issue
endmodule : bus_master_model

// ===== tb_top.sv
/*
 * Self-checking bench for the bus memory controller: RAM, flash, I/O and
 * error transfers, checking strobe shapes and acknowledge timing.
 * Assumes the package constants and the cycle figures of the hand-over.
 */
`timescale 1ns/1ps
module tb_top;
    // ********************************************************************
    // strobe snapshot layout: bws[16:9] fcs foe scs soe sram_address_strobe_n adv xcs[2:1] xoe
    // ********************************************************************
    localparam logic [16:0] ALL = 17'h1FFFF;
    localparam logic [16:0] M_FCS = 17'h00100;
    localparam logic [16:0] M_FOE = 17'h00080;
    localparam logic [16:0] M_SCS = 17'h00040;
    localparam logic [16:0] M_SOE = 17'h00020;
    localparam logic [16:0] M_SRAM_ADDRESS_STROBE_N = 17'h00010;
    localparam logic [16:0] M_ADV = 17'h00008;
    localparam logic [16:0] M_XCS0 = 17'h00002;
    localparam logic [16:0] M_XCS1 = 17'h00004;
    localparam logic [16:0] M_XOE = 17'h00001;

    logic clk;
    logic rst_b;
    logic [31:0] address;
    logic transfer_start_n;
    logic [4:0] transfer_type;
    logic [2:0] transfer_size;
    logic burst_indicator_n;
    logic address_ack_n;
    logic data_transfer_ack_n;
    logic transfer_error_ack_n;
    logic [7:0] byte_write_strobe_n;
    logic flash_chip_select_n;
    logic flash_output_enable_n;
    logic sram_chip_select_n;
    logic sram_output_enable_n;
    logic sram_address_strobe_n;
    logic sram_burst_advance_n;
    logic [1:0] io_chip_select_n;
    logic io_output_enable_n;
    int errors;
    int checks_done;
    logic [16:0] snap [0:15];
    wire logic [16:0] strobes = {byte_write_strobe_n, flash_chip_select_n, flash_output_enable_n,
        sram_chip_select_n, sram_output_enable_n, sram_address_strobe_n, sram_burst_advance_n,
        io_chip_select_n, io_output_enable_n};

    bus_mem_ctrl u_dut (.clk(clk), .rst_b(rst_b), .address(address), .transfer_start_n(transfer_start_n),
        .transfer_type(transfer_type), .transfer_size(transfer_size), .burst_indicator_n(burst_indicator_n),
        .address_ack_n(address_ack_n), .data_transfer_ack_n(data_transfer_ack_n),
        .transfer_error_ack_n(transfer_error_ack_n), .byte_write_strobe_n(byte_write_strobe_n),
        .flash_chip_select_n(flash_chip_select_n), .flash_output_enable_n(flash_output_enable_n),
        .sram_chip_select_n(sram_chip_select_n), .sram_output_enable_n(sram_output_enable_n),
        .sram_address_strobe_n(sram_address_strobe_n), .sram_burst_advance_n(sram_burst_advance_n),
        .io_chip_select_n(io_chip_select_n), .io_output_enable_n(io_output_enable_n));

    bus_master_model u_master (.clk(clk), .address(address), .transfer_start_n(transfer_start_n),
        .transfer_type(transfer_type), .transfer_size(transfer_size), .burst_indicator_n(burst_indicator_n),
        .address_ack_n(address_ack_n), .data_transfer_ack_n(data_transfer_ack_n),
        .transfer_error_ack_n(transfer_error_ack_n));

    initial begin
        clk = 1'b0;
        forever begin
            #2 clk = ~clk;
        end
    end

    // ********************************************************************
    // shared checking tasks
    // ********************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic at(input int k, input logic [16:0] low);
        chk($sformatf("strobes in cycle %0d", k), {15'h0, ALL & ~low}, {15'h0, snap[k]});
    endtask : at

    // issues one transfer, snapshots strobes per cycle, checks acknowledge timing
    task automatic go(input logic [31:0] a, input logic [4:0] tt, input logic [2:0] sz, input logic bn,
                      input int n_ta, input int c_ta, input int c_address_ack_n, input int c_tea);
        fork
            u_master.issue(a, tt, sz, bn);
            for (int k = 0; k < 16; k++) begin
                @(posedge clk);
                #1;
                snap[k] = strobes;
            end
        join
        chk("data ack count", n_ta, u_master.ta_count);
        chk("first data ack cycle", c_ta, u_master.first_ta);
        chk("address ack cycle", c_address_ack_n, u_master.address_ack_n_cyc);
        chk("error ack cycle", c_tea, u_master.tea_cyc);
        repeat (2) @(posedge clk);
        #1;
    endtask : go

    task automatic close_out;
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // ********************************************************************
    // scenarios
    // ********************************************************************
    task automatic ram_burst_read;
        go(32'h0000_0000, mbc_pkg::TT_READ, 3'h0, 1'b0, 4, 3, 6, 0);
        at(1, M_SCS | M_SOE | M_SRAM_ADDRESS_STROBE_N);
        at(2, M_SCS | M_SOE);
        at(3, M_SCS | M_SOE);
        at(4, M_SCS | M_SOE | M_ADV);
        at(6, M_SCS | M_SOE | M_ADV);
        at(7, M_SRAM_ADDRESS_STROBE_N);
        at(8, 17'h0);
    endtask : ram_burst_read

    task automatic ram_write;
        go(32'h0000_0004, mbc_pkg::TT_WRITE_FLUSH, 3'h4, 1'b1, 1, 3, 3, 0);
        at(1, {8'hF0, 9'h0} | M_SCS | M_SRAM_ADDRESS_STROBE_N);
        at(3, {8'hF0, 9'h0} | M_SCS);
        at(4, M_SRAM_ADDRESS_STROBE_N);
    endtask : ram_write

    task automatic flash_access;
        go(32'hC000_0000, mbc_pkg::TT_READ, 3'h0, 1'b1, 1, 6, 6, 0);
        at(1, M_FCS | M_FOE);
        at(6, M_FCS | M_FOE);
        at(7, 17'h0);
        go(32'hC000_0002, mbc_pkg::TT_WRITE_KILL, 3'h2, 1'b1, 1, 6, 6, 0);
        at(1, {8'h0C, 9'h0} | M_FCS);
    endtask : flash_access

    task automatic io_access;
        go(32'h8000_0001, mbc_pkg::TT_WRITE_FLUSH, 3'h1, 1'b1, 1, 12, 12, 0);
        at(1, {8'h02, 9'h0} | M_XCS1);
        at(13, 17'h0);
        go(32'h4000_0000, mbc_pkg::TT_READ_MODIFY, 3'h0, 1'b1, 1, 4, 4, 0);
        at(1, M_XCS0 | M_XOE);
        go(32'h4000_0006, mbc_pkg::TT_WRITE_FLUSH, 3'h2, 1'b1, 1, 4, 4, 0);
        at(1, {8'hC0, 9'h0} | M_XCS0);
    endtask : io_access

    // flash burst, reserved type, doubleword crossing: all end in error ack
    task automatic refusals;
        go(32'hC000_0000, mbc_pkg::TT_READ, 3'h0, 1'b0, 0, 0, 1, 1);
        at(1, 17'h0);
        go(32'h0000_0000, 5'h00, 3'h4, 1'b1, 0, 0, 1, 1);
        go(32'h0000_0006, mbc_pkg::TT_READ, 3'h4, 1'b1, 0, 0, 1, 1);
        at(1, 17'h0);
    endtask : refusals

    initial begin
        #20000;
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        rst_b = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        chk("strobes in reset", {15'h0, ALL}, {15'h0, strobes});
        chk("acks in reset", 32'h7, {29'h0, address_ack_n, data_transfer_ack_n, transfer_error_ack_n});
        rst_b = 1'b1;
        @(posedge clk);
        #1;
        chk("strobes after reset", {15'h0, ALL}, {15'h0, strobes});
        ram_burst_read();
        ram_write();
        flash_access();
        io_access();
        refusals();
        ram_burst_read();
        close_out();
    end
endmodule : tb_top
